// ---- dv/wake_event_status_enable_tb.sv ----
// self-checking testbench for the wake event status and enable block
`default_nettype none
module wake_event_status_enable_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, main_reset, psel, penable, pwrite, pready, pslverr; // clock, resets, apb controls
  logic wake_request_out_n, irq, err, wake_seen; // block outputs, captured error and host wake flag
  logic [7:0] paddr; // apb byte address
  logic [31:0] pwdata, prdata, rd; // apb data and captured read data
  logic [3:0] pstrb; // write strobes
  wses_pkg::wses_pins_t wake_pins; // wake pins driven by the bench
  wses_pkg::wses_ext_sts_t ext_status; // sibling status levels
  wses_pkg::wses_ext_en_t ext_enable; // sibling enable levels
  int fails, n_compared; // mismatch and comparison counters
  wses_top dut_u (.pclk(pclk), .presetn(presetn), .main_reset(main_reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wake_pins(wake_pins), .ext_status(ext_status), .ext_enable(ext_enable),
    .wake_request_out_n(wake_request_out_n), .irq(irq));
  wses_host_model host_u (.pclk(pclk), .presetn(presetn), .wake_request_out_n(wake_request_out_n),
    .wake_seen(wake_seen));
  // free-running 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // verdict and end of run, shared by the main flow and the hang guard
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one comparison, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one apb transfer; entered just after a rising edge, leaves one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      $display("ERROR %0t apb transfer never completed", $time);
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // read one register and compare
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e, m);
  endtask
  // raise one wake pin long enough for the synchroniser, then let status settle
  task automatic pin(input int i);
    wake_pins <= wses_pkg::wses_pins_t'(16'h0001 << i);
    repeat (4) @(posedge pclk);
    wake_pins <= wses_pkg::wses_pins_t'(16'h0000);
    repeat (6) @(posedge pclk);
  endtask
  // values after standby reset
  task automatic t_reset_vals;
    rd_chk(8'h1c, 32'h0, "status hi after reset");
    rd_chk(8'h20, 32'h0, "status 50s after reset");
    rd_chk(8'h28, 32'h0, "periph enable after reset");
    rd_chk(8'h2c, 32'h0, "pins 10s enable after reset");
    rd_chk(8'h08, 32'h0, "global enable after reset");
    chk({31'h0, wake_request_out_n}, 32'h1, "request idle");
    chk({31'h0, wake_seen}, 32'h0, "host idle at start");
  endtask
  // enable registers, reserved and unmapped places
  task automatic t_enables;
    apb(1'b1, 8'h28, 32'h0000_00ff);
    rd_chk(8'h28, 32'h0000_00fe, "periph enable bit 0 reserved");
    apb(1'b1, 8'h2c, 32'h0000_00a5);
    rd_chk(8'h2c, 32'h0000_00a5, "pins 10s enable");
    pstrb <= 4'h0;
    apb(1'b1, 8'h2c, 32'h0000_00ff);
    pstrb <= 4'hf;
    rd_chk(8'h2c, 32'h0000_00a5, "write without lane zero ignored");
    apb(1'b1, 8'h24, 32'h0000_00ff);
    rd_chk(8'h24, 32'h0, "reserved reads zero");
    chk({31'h0, err}, 32'h0, "reserved no error");
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped reads zero");
  endtask
  // every pin sets its own bit with enables off; then one-write clears
  task automatic t_status;
    for (int i = 0; i < 16; i++) begin
      pin(i);
      apb(1'b0, (i < 8) ? 8'h1c : 8'h20, 32'h0);
      chk(rd, (32'h2 << (i % 8)) - 32'h1, "status bit map");
    end
    apb(1'b1, 8'h1c, 32'h0000_000f);
    rd_chk(8'h1c, 32'h0000_00f0, "one write clears");
    apb(1'b1, 8'h1c, 32'h0);
    rd_chk(8'h1c, 32'h0000_00f0, "zero write keeps hi");
    apb(1'b1, 8'h20, 32'h0);
    rd_chk(8'h20, 32'h0000_00ff, "zero write no effect");
  endtask
  // request output gated by enables and the global bit
  task automatic t_request;
    ext_enable <= wses_pkg::wses_ext_en_t'(16'h0010);
    repeat (4) @(posedge pclk);
    chk({31'h0, wake_request_out_n}, 32'h1, "global off blocks");
    apb(1'b1, 8'h08, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk({31'h0, wake_request_out_n}, 32'h0, "request asserted");
    ext_enable <= wses_pkg::wses_ext_en_t'(16'h0000);
    repeat (4) @(posedge pclk);
    chk({31'h0, wake_request_out_n}, 32'h1, "disabled source silent");
    ext_status <= wses_pkg::wses_ext_sts_t'(16'h0001);
    repeat (4) @(posedge pclk);
    chk({31'h0, wake_request_out_n}, 32'h0, "pin 10 enable");
    ext_status <= wses_pkg::wses_ext_sts_t'(16'h0100);
    repeat (4) @(posedge pclk);
    chk({31'h0, wake_request_out_n}, 32'h1, "reserved enable bit");
    chk({31'h0, wake_seen}, 32'h1, "host saw request");
    ext_status <= wses_pkg::wses_ext_sts_t'(16'h0000);
  endtask
  // interrupt raised, read-cleared and masked
  task automatic t_irq;
    // earlier scenarios left every cause latched; this read also clears them
    rd_chk(8'h40, 32'h0000_0007, "irq causes latched");
    apb(1'b1, 8'h20, 32'h0000_0001);
    apb(1'b1, 8'h44, 32'h0000_0007);
    pin(8);
    chk({31'h0, irq}, 32'h1, "irq raised");
    rd_chk(8'h40, 32'h0000_0002, "irq status 50s event");
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0, "irq cleared by read");
    apb(1'b1, 8'h44, 32'h0);
    pin(9);
    chk({31'h0, irq}, 32'h0, "irq masked");
  endtask
  // main reset keeps wake registers; standby reset clears them
  task automatic t_resets;
    apb(1'b1, 8'h44, 32'h0000_0005);
    main_reset <= 1'b1;
    repeat (2) @(posedge pclk);
    main_reset <= 1'b0;
    @(posedge pclk);
    rd_chk(8'h1c, 32'h0000_00f0, "status kept");
    rd_chk(8'h2c, 32'h0000_00a5, "enable kept");
    rd_chk(8'h08, 32'h0000_0001, "global kept");
    rd_chk(8'h44, 32'h0, "mask cleared by main reset");
    rd_chk(8'h40, 32'h0, "irq status cleared by main reset");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(8'h1c, 32'h0, "status cleared");
    rd_chk(8'h28, 32'h0, "enable cleared");
    rd_chk(8'h20, 32'h0, "upper status cleared");
    rd_chk(8'h08, 32'h0, "global cleared");
    chk({31'h0, wake_seen}, 32'h0, "host idle after reset");
  endtask
  // main sequence
  initial begin
    {presetn, main_reset, psel, penable, pwrite} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    wake_pins = wses_pkg::wses_pins_t'(16'h0000);
    ext_status = wses_pkg::wses_ext_sts_t'(16'h0000);
    ext_enable = wses_pkg::wses_ext_en_t'(16'h0000);
    fails = 0;
    n_compared = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_vals();
    t_enables();
    t_status();
    t_request();
    t_irq();
    t_resets();
    stop_test();
  end
endmodule // wake_event_status_enable_tb
`default_nettype wire

// ---- dv/wses_host_model.sv ----
// host-side model of the chipset logic that receives the wake request
`default_nettype none
module wses_host_model (
  input wire logic pclk, // bus clock
  input wire logic presetn, // standby-supply power-on reset
  input wire logic wake_request_out_n, // active-low request from the block
  output logic wake_seen // sticky flag, request seen low
);
  timeunit 1ns;
  timeprecision 1ps;
  // the host reacts to the level, so one low sample is enough to latch a wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_seen <= 1'b0;
    end else if (wake_request_out_n == 1'b0) begin
      wake_seen <= 1'b1; // request seen
    end
  end
endmodule // wses_host_model
`default_nettype wire

// ---- verilog/wses_consts.svh ----
// constants for the wake event status and enable block
`ifndef WSES_CONSTS_SVH
`define WSES_CONSTS_SVH
// register indices; byte address is four times the index
`define WSES_IDX_GLOBAL 6'h02
`define WSES_IDX_STS_HI 6'h07
`define WSES_IDX_STS_50 6'h08
`define WSES_IDX_RSVD 6'h09
`define WSES_IDX_EN_PERIPH 6'h0a
`define WSES_IDX_EN_10S 6'h0b
`define WSES_IDX_IRQ_STS 6'h10
`define WSES_IDX_IRQ_MASK 6'h11
// reset and fill values
`define WSES_RST_BYTE 8'h00
`define WSES_RST_IRQ 3'h0
`define WSES_ZERO32 32'h0000_0000
`define WSES_RST_BIT 1'b0
`define WSES_REQ_IDLE 1'b1
// field positions
`define WSES_GLOBAL_BIT 0
`define WSES_PERIPH_RSVD_BIT 0
`define WSES_IRQ_HI 0
`define WSES_IRQ_50 1
`define WSES_IRQ_REQ 2
// widths
`define WSES_NPINS 16
`define WSES_IRQ_W 3
`endif

// ---- verilog/wses_pkg.sv ----
// types shared by the wake event status and enable block
`default_nettype none
package wses_pkg;
  // the sixteen asynchronous wake pins, one byte per status register
  typedef struct packed {
    logic [7:0] pins_50s; // general_io_57 .. general_io_50
    logic [7:0] pins_hi; // general_io_61,60,43,41,33,32,31,30
  } wses_pins_t;
  // status bits kept by sibling registers, same clock domain
  typedef struct packed {
    logic [7:0] periph; // peripheral wake status, bit 0 unused
    logic [7:0] pins_10s; // general_io_17 .. general_io_10
  } wses_ext_sts_t;
  // enable bits kept by sibling registers for our status bits
  typedef struct packed {
    logic [7:0] pins_50s; // enables for pins 50..57
    logic [7:0] pins_hi; // enables for pins 30..61 group
  } wses_ext_en_t;
endpackage
`default_nettype wire

// ---- verilog/wses_top.sv ----
// wake event status and enable registers with apb slave and interrupt
//
// The APB interface to the registers is this design's own decision.
`include "wses_consts.svh"
`default_nettype none
module wses_top (
  input wire logic pclk, // 25 MHz bus clock
  input wire logic presetn, // standby-supply power-on reset
  input wire logic main_reset, // main, soft or hard reset level
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb write strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire wses_pkg::wses_pins_t wake_pins, // asynchronous wake pins
  input wire wses_pkg::wses_ext_sts_t ext_status, // sibling status bits
  input wire wses_pkg::wses_ext_en_t ext_enable, // sibling enable bits
  output logic wake_request_out_n, // active-low wake request
  output logic irq // level interrupt
);

  // register index of a byte address, low bits must be zero
  function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
    hit = (addr[1:0] == 2'b00) && (addr[7:2] == idx);
  endfunction

  // synchroniser stages, three flops per pin
  logic [15:0] sync1_reg; // first stage, read only by stage two
  logic [15:0] sync2_reg; // second stage
  logic [15:0] sync3_reg; // third stage
  logic [15:0] level_reg; // filtered pin level
  logic [15:0] event_next; // one-cycle rising event per pin

  // register file
  logic [7:0] sts_hi_reg; // status, pins 30..61 group
  logic [7:0] sts_50_reg; // status, pins 50..57
  logic [7:0] en_periph_reg; // peripheral enables
  logic [7:0] en_10s_reg; // enables, pins 10..17
  logic wake_global_enable_reg; // global wake enable
  logic [2:0] irq_sts_reg; // sticky interrupt causes
  logic [2:0] irq_mask_reg; // interrupt mask
  logic [2:0] irq_set; // interrupt cause events

  // bus decode
  logic access; // access phase waiting for ready
  logic done; // completing edge of a transfer
  logic wr_done; // completing write
  logic rd_done; // completing read
  logic wr_lane0; // byte lane zero is written
  logic mapped; // address decodes to a register
  logic [7:0] rd_byte; // read mux result
  logic wake_cond; // request condition
  logic wake_cond_q; // request condition one cycle ago

  // pin synchronisers; the first flop feeds nothing but the second
  // stages reset low like an idle pin, so release brings no false event
  generate
    for (genvar i = 0; i < `WSES_NPINS; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_reg[i] <= `WSES_RST_BIT;
          sync2_reg[i] <= `WSES_RST_BIT;
          sync3_reg[i] <= `WSES_RST_BIT;
        end else begin
          sync1_reg[i] <= wake_pins[i];
          sync2_reg[i] <= sync1_reg[i];
          sync3_reg[i] <= sync2_reg[i];
        end
      end
      // level changes only once stages two and three agree
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          level_reg[i] <= `WSES_RST_BIT;
        end else if (sync2_reg[i] == sync3_reg[i]) begin
          level_reg[i] <= sync3_reg[i];
        end
      end
      // a wake event is the agreed rise of the pin
      always_comb begin
        event_next[i] = sync2_reg[i] & sync3_reg[i] & ~level_reg[i];
      end
    end
  endgenerate

  // apb phases; one wait state so every output is a flop
  assign access = psel & penable & ~pready;
  assign done = psel & penable & pready;
  assign wr_done = done & pwrite;
  assign rd_done = done & ~pwrite;
  assign wr_lane0 = wr_done & pstrb[0];

  // address decode, unmapped addresses answer with an error
  always_comb begin
    mapped = hit(paddr, `WSES_IDX_GLOBAL) | hit(paddr, `WSES_IDX_STS_HI) |
             hit(paddr, `WSES_IDX_STS_50) | hit(paddr, `WSES_IDX_RSVD) |
             hit(paddr, `WSES_IDX_EN_PERIPH) | hit(paddr, `WSES_IDX_EN_10S) |
             hit(paddr, `WSES_IDX_IRQ_STS) | hit(paddr, `WSES_IDX_IRQ_MASK);
  end

  // read mux, narrow data in the low byte
  always_comb begin
    rd_byte = `WSES_RST_BYTE;
    if (hit(paddr, `WSES_IDX_GLOBAL)) begin
      rd_byte[`WSES_GLOBAL_BIT] = wake_global_enable_reg;
    end else if (hit(paddr, `WSES_IDX_STS_HI)) begin
      rd_byte = sts_hi_reg;
    end else if (hit(paddr, `WSES_IDX_STS_50)) begin
      rd_byte = sts_50_reg;
    end else if (hit(paddr, `WSES_IDX_EN_PERIPH)) begin
      rd_byte = en_periph_reg;
    end else if (hit(paddr, `WSES_IDX_EN_10S)) begin
      rd_byte = en_10s_reg;
    end else if (hit(paddr, `WSES_IDX_IRQ_STS)) begin
      rd_byte[2:0] = irq_sts_reg;
    end else if (hit(paddr, `WSES_IDX_IRQ_MASK)) begin
      rd_byte[2:0] = irq_mask_reg;
    end
    // reserved index and unmapped space fall through as zero
  end

  // bus answer flops, ready raised for exactly one cycle
  // write accesses answer zero so stale read data never reaches the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= `WSES_RST_BIT;
      pslverr <= `WSES_RST_BIT;
      prdata <= `WSES_ZERO32;
    end else if (access) begin
      pready <= 1'b1;
      pslverr <= ~mapped;
      prdata <= pwrite ? `WSES_ZERO32 : {24'h00_0000, rd_byte};
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `WSES_ZERO32;
    end
  end

  // status for pins 30..61 group; set wins over a clear in the same cycle
  // only the standby reset reaches here, main reset is ignored on purpose
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_hi_reg <= `WSES_RST_BYTE;
    end else begin
      sts_hi_reg <= (sts_hi_reg & ~((wr_lane0 && hit(paddr, `WSES_IDX_STS_HI)) ? pwdata[7:0] : 8'h00))
                    | event_next[7:0];
    end
  end

  // status for pins 50..57, same sticky write-one-to-clear scheme
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_50_reg <= `WSES_RST_BYTE;
    end else begin
      sts_50_reg <= (sts_50_reg & ~((wr_lane0 && hit(paddr, `WSES_IDX_STS_50)) ? pwdata[7:0] : 8'h00))
                    | event_next[15:8];
    end
  end

  // enable registers, untouched by main reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_periph_reg <= `WSES_RST_BYTE;
      en_10s_reg <= `WSES_RST_BYTE;
    end else if (wr_lane0) begin
      if (hit(paddr, `WSES_IDX_EN_PERIPH)) begin
        en_periph_reg <= {pwdata[7:1], 1'b0};
      end
      if (hit(paddr, `WSES_IDX_EN_10S)) begin
        en_10s_reg <= pwdata[7:0];
      end
    end
  end

  // global enable, bits above zero are reserved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_global_enable_reg <= `WSES_RST_BIT;
    end else if (wr_lane0 && hit(paddr, `WSES_IDX_GLOBAL)) begin
      wake_global_enable_reg <= pwdata[`WSES_GLOBAL_BIT];
    end
  end

  // request condition over all sources this block sees
  // our status meets sibling enables and sibling status meets our enables,
  // so each half of every source pair lives on one side only
  always_comb begin
    wake_cond = wake_global_enable_reg &
                (|(sts_hi_reg & ext_enable.pins_hi) |
                 |(sts_50_reg & ext_enable.pins_50s) |
                 |(ext_status.periph & en_periph_reg) |
                 |(ext_status.pins_10s & en_10s_reg));
  end

  // request output from a flop, one cycle behind the condition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_request_out_n <= `WSES_REQ_IDLE;
      wake_cond_q <= `WSES_RST_BIT;
    end else begin
      wake_request_out_n <= ~wake_cond;
      wake_cond_q <= wake_cond;
    end
  end

  // interrupt causes: new pin events and a fresh wake request
  // a pin held high raises its cause once; the level filter blocks repeats
  assign irq_set[`WSES_IRQ_HI] = |event_next[7:0];
  assign irq_set[`WSES_IRQ_50] = |event_next[15:8];
  assign irq_set[`WSES_IRQ_REQ] = wake_cond & ~wake_cond_q;

  // interrupt status, cleared by its read, set wins over the read
  // main reset clears the interrupt side only; wake registers keep state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_reg <= `WSES_RST_IRQ;
    end else if (main_reset) begin
      irq_sts_reg <= irq_set;
    end else if (rd_done && hit(paddr, `WSES_IDX_IRQ_STS)) begin
      irq_sts_reg <= irq_set;
    end else begin
      irq_sts_reg <= irq_sts_reg | irq_set;
    end
  end

  // interrupt mask, one bit per cause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= `WSES_RST_IRQ;
    end else if (main_reset) begin
      irq_mask_reg <= `WSES_RST_IRQ;
    end else if (wr_lane0 && hit(paddr, `WSES_IDX_IRQ_MASK)) begin
      irq_mask_reg <= pwdata[2:0];
    end
  end

  // level interrupt from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= `WSES_RST_BIT;
    end else begin
      irq <= |(irq_sts_reg & irq_mask_reg);
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rd_rsvd;
    psel && !penable && !pwrite && hit(paddr, `WSES_IDX_RSVD) ##1 psel && penable;
  endsequence
  sequence s_ready_zero;
    pready && (prdata == `WSES_ZERO32);
  endsequence

  chk_status_set_event: assert property (
    (event_next[7:0] != 8'h00) |=> ((sts_hi_reg & $past(event_next[7:0])) == $past(event_next[7:0])))
    else $error("pin event did not set status");

  chk_w1c_clears_bits: assert property (
    wr_lane0 && hit(paddr, `WSES_IDX_STS_50)
    |=> sts_50_reg == (($past(sts_50_reg) & ~$past(pwdata[7:0])) | $past(event_next[15:8])))
    else $error("write one did not clear status");

  chk_zero_write_keeps: assert property (
    wr_done && hit(paddr, `WSES_IDX_STS_HI) && (pwdata[7:0] == 8'h00) && (event_next[7:0] == 8'h00)
    |=> $stable(sts_hi_reg))
    else $error("zero write changed status");

  chk_status_sticky_reset: assert property (
    !(wr_lane0 && hit(paddr, `WSES_IDX_STS_HI)) |=> ((sts_hi_reg & $past(sts_hi_reg)) == $past(sts_hi_reg)))
    else $error("status bit lost without clear");

  chk_enable_main_reset: assert property (
    main_reset && !wr_lane0 |=> $stable(en_periph_reg) && $stable(en_10s_reg) && $stable(wake_global_enable_reg))
    else $error("enable changed across main reset");

  chk_request_follows: assert property (
    wake_cond |=> !wake_request_out_n ##0 (wake_cond_q == 1'b1))
    else $error("wake request not driven");

  chk_global_blocks: assert property (
    !wake_global_enable_reg |=> wake_request_out_n)
    else $error("request while globally disabled");

  chk_masked_source: assert property (
    (ext_enable == 16'h0000) && (en_periph_reg == 8'h00) && (en_10s_reg == 8'h00) |=> wake_request_out_n)
    else $error("disabled source drove request");

  chk_reserved_reads_zero: assert property (
    s_rd_rsvd |=> s_ready_zero)
    else $error("reserved index read nonzero");

  chk_periph_bit_zero: assert property (
    en_periph_reg[`WSES_PERIPH_RSVD_BIT] == 1'b0)
    else $error("reserved enable bit set");

  chk_ready_one_cycle: assert property (
    pready |=> !pready)
    else $error("ready held more than one cycle");

  // per-source gating, register writes, bus error and interrupt
  chk_upper_status_set: assert property (
    (event_next[15:8] != 8'h00) |=> ((sts_50_reg & $past(event_next[15:8])) == $past(event_next[15:8])))
    else $error("pin event did not set upper status");

  chk_upper_status_sticky: assert property (
    !(wr_lane0 && hit(paddr, `WSES_IDX_STS_50)) |=> ((sts_50_reg & $past(sts_50_reg)) == $past(sts_50_reg)))
    else $error("upper status bit lost without clear");

  chk_zero_write_upper: assert property (
    wr_done && hit(paddr, `WSES_IDX_STS_50) && (pwdata[7:0] == 8'h00) && (event_next[15:8] == 8'h00)
    |=> $stable(sts_50_reg))
    else $error("zero write changed upper status");

  chk_enable_write_lands: assert property (
    wr_lane0 && hit(paddr, `WSES_IDX_EN_10S) |=> (en_10s_reg == $past(pwdata[7:0])))
    else $error("pin enable write lost");

  chk_global_write_lands: assert property (
    wr_lane0 && hit(paddr, `WSES_IDX_GLOBAL) |=> (wake_global_enable_reg == $past(pwdata[`WSES_GLOBAL_BIT])))
    else $error("global enable write lost");

  chk_disabled_silent: assert property (
    ((sts_hi_reg & ext_enable.pins_hi) == 8'h00) && ((sts_50_reg & ext_enable.pins_50s) == 8'h00) &&
    ((ext_status.periph & en_periph_reg) == 8'h00) && ((ext_status.pins_10s & en_10s_reg) == 8'h00)
    |=> wake_request_out_n)
    else $error("request without an enabled source");

  chk_enabled_wakes: assert property (
    wake_global_enable_reg && ((ext_status.pins_10s & en_10s_reg) != 8'h00) |=> !wake_request_out_n)
    else $error("enabled source did not wake");

  chk_event_single_pulse: assert property (
    (event_next != 16'h0000) |=> ((event_next & $past(event_next)) == 16'h0000))
    else $error("pin event longer than one cycle");

  sequence s_access_unmapped;
    psel && penable && !pready && !mapped;
  endsequence
  sequence s_ready_error;
    pready && pslverr;
  endsequence

  chk_unmapped_error: assert property (
    s_access_unmapped |=> s_ready_error)
    else $error("unmapped access without error");

  chk_irq_read_clears: assert property (
    rd_done && hit(paddr, `WSES_IDX_IRQ_STS) && !main_reset |=> (irq_sts_reg == $past(irq_set)))
    else $error("interrupt status not cleared by read");

  chk_irq_level: assert property (
    ((irq_sts_reg & irq_mask_reg) != 3'h0) |=> irq)
    else $error("interrupt not raised for unmasked cause");

endmodule // wses_top
`default_nettype wire
